// ---- core/osc_top.sv ----
// octal switch channel control: register file, input logic, channels
`default_nettype none
module osc_top #(
	parameter int NCH = osc_pkg::NCH
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// device pins
	input  wire logic [3:0]  par_in,
	input  wire logic        input_polarity_select,
	input  wire logic        reset_pin_n,
	// sensed conditions from the output stages
	input  wire logic [7:0]  overtemp_sense,
	input  wire logic [7:0]  current_limit_sense,
	// output stage drive
	output logic      [7:0]  power_output_stage,
	output logic      [7:0]  slew_slow
);
	localparam int SW = 2 * NCH + 6;

	osc_pkg::osc_cfg_t cfg_q;
	osc_pkg::osc_cfg_t cfg_d;
	logic [15:0]       diag_q;
	logic [15:0]       diag_d;
	logic [31:0]       prdata_q;
	logic [31:0]       prdata_d;
	logic              pready_q;
	logic              pready_d;
	logic              pslverr_q;
	logic              pslverr_d;
	logic [SW-1:0]     raw_in;
	logic [SW-1:0]     syn_in;
	logic [3:0]        par_s;
	logic              pol_s;
	logic              rst_pin_s;
	logic [7:0]        ovt_s;
	logic [7:0]        lim_s;
	logic              sleep;
	logic [3:0]        par_act;
	logic [7:0]        par_on;
	logic [7:0]        eff;
	logic [7:0]        stage_on;
	logic [7:0]        ovt_evt;
	logic [7:0]        ovl_evt;
	logic              access;
	logic              done;
	logic              wr_en;
	logic              hit;

	// all pin and sense inputs arrive from outside the clock domain
	assign raw_in = {current_limit_sense, overtemp_sense, reset_pin_n,
	                 input_polarity_select, par_in};

	osc_sync #(
		.W(SW)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (raw_in),
		.sync_out (syn_in)
	);

	assign par_s     = syn_in[3:0];
	assign pol_s     = syn_in[4];
	assign rst_pin_s = syn_in[5];
	assign ovt_s     = syn_in[13:6];
	assign lim_s     = syn_in[21:14];
	// the filtered reset pin reads low out of reset, so sleep is held
	// until the pin is seen high for two agreeing samples
	assign sleep     = ~rst_pin_s;

	always_comb begin
		par_act = pol_s ? par_s : ~par_s;
	end

	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			logic direct;
			if (i < 3) begin : g_dir
				assign direct = par_act[i];
			end else begin : g_nodir
				assign direct = 1'b0;
			end
			// mapped input joins any channel, channels four to eight have no other
			assign par_on[i] = direct | (cfg_q.map[i] & par_act[3]);
			// serial bit is active high, bol bit one means and
			assign eff[i] = cfg_q.bol[i] ? (par_on[i] & cfg_q.ctl[i])
			                             : (par_on[i] | cfg_q.ctl[i]);

			osc_chan u_chan (
				.pclk      (pclk),
				.presetn   (presetn),
				.sleep     (sleep),
				.eff_in    (eff[i]),
				.ovt_latch (cfg_q.ovt[i]),
				.ovl_shut  (cfg_q.ovl[i]),
				.slow      (cfg_q.sle[i]),
				.overtemp  (ovt_s[i]),
				.limiting  (lim_s[i]),
				.stage_on  (stage_on[i]),
				.ovt_evt   (ovt_evt[i]),
				.ovl_evt   (ovl_evt[i])
			);
		end
	endgenerate

	// one wait state so read data comes from a flop
	always_comb begin
		access    = psel & penable;
		done      = access & pready_q;
		wr_en     = done & pwrite & ~pslverr_q;
		pready_d  = access & ~pready_q;
		hit       = 1'b1;
		prdata_d  = 32'h00000000;
		case (paddr)
			osc_pkg::ADDR_MAP:  prdata_d[7:0]  = cfg_q.map;
			osc_pkg::ADDR_BOL:  prdata_d[7:0]  = cfg_q.bol;
			osc_pkg::ADDR_OVL:  prdata_d[7:0]  = cfg_q.ovl;
			osc_pkg::ADDR_OVT:  prdata_d[7:0]  = cfg_q.ovt;
			osc_pkg::ADDR_SLE:  prdata_d[7:0]  = cfg_q.sle;
			osc_pkg::ADDR_STA:  prdata_d[7:0]  = stage_on;
			osc_pkg::ADDR_CTL:  prdata_d[7:0]  = cfg_q.ctl;
			osc_pkg::ADDR_DIAG: prdata_d[15:0] = diag_q;
			default:            hit            = 1'b0;
		endcase
		pslverr_d = pready_d & ~hit;
		if (!pready_d) begin
			prdata_d = prdata_q;
		end
	end

	always_comb begin
		cfg_d = cfg_q;
		if (wr_en) begin
			case (paddr)
				osc_pkg::ADDR_MAP: cfg_d.map = pwdata[7:0];
				osc_pkg::ADDR_BOL: cfg_d.bol = pwdata[7:0];
				osc_pkg::ADDR_OVL: cfg_d.ovl = pwdata[7:0];
				osc_pkg::ADDR_OVT: cfg_d.ovt = pwdata[7:0];
				osc_pkg::ADDR_SLE: cfg_d.sle = pwdata[7:0];
				osc_pkg::ADDR_CTL: cfg_d.ctl = pwdata[7:0];
				default:           cfg_d     = cfg_q;
			endcase
		end
		// serial on bits cleared in sleep; outputs stay off in sleep, then or channels follow pins and and channels stay off
		if (sleep) begin
			cfg_d.ctl = osc_pkg::ZERO_RST;
		end
	end

	// write one to clear; a fresh event in the same cycle wins
	always_comb begin
		diag_d = diag_q;
		if (wr_en && paddr == osc_pkg::ADDR_DIAG) begin
			diag_d = diag_q & ~pwdata[15:0];
		end
		diag_d[osc_pkg::DIAG_OVT_LSB +: 8] =
			diag_d[osc_pkg::DIAG_OVT_LSB +: 8] | ovt_evt;
		diag_d[osc_pkg::DIAG_OVL_LSB +: 8] =
			diag_d[osc_pkg::DIAG_OVL_LSB +: 8] | ovl_evt;
		if (sleep) begin
			diag_d = osc_pkg::DIAG_RST;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q.map <= osc_pkg::MAP_RST;
			cfg_q.bol <= osc_pkg::ZERO_RST;
			cfg_q.ovl <= osc_pkg::ZERO_RST;
			cfg_q.ovt <= osc_pkg::ZERO_RST;
			cfg_q.sle <= osc_pkg::ZERO_RST;
			cfg_q.ctl <= osc_pkg::ZERO_RST;
			diag_q    <= osc_pkg::DIAG_RST;
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			cfg_q     <= cfg_d;
			diag_q    <= diag_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata             = prdata_q;
	assign pready             = pready_q;
	assign pslverr            = pslverr_q;
	assign power_output_stage = stage_on;
	assign slew_slow          = cfg_q.sle;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_ctl_write;
		wr_en && paddr == osc_pkg::ADDR_CTL && !sleep;
	endsequence

	property p_ctl_write;
		s_ctl_write |=> cfg_q.ctl == $past(pwdata[7:0]);
	endproperty
	a_ctl_write: assert property (p_ctl_write)
		else $error("serial control write not stored");

	property p_sleep_clear;
		sleep |=> cfg_q.ctl == 8'h00 && diag_q == 16'h0000;
	endproperty
	a_sleep_clear: assert property (p_sleep_clear)
		else $error("sleep did not clear serial bits and diagnosis");

	property p_sleep_off;
		sleep ##1 sleep |=> power_output_stage == 8'h00;
	endproperty
	a_sleep_off: assert property (p_sleep_off)
		else $error("output on during sleep");

	property p_map_only_by_write;
		$changed(cfg_q.map) |-> $past(wr_en) &&
			$past(paddr) == osc_pkg::ADDR_MAP;
	endproperty
	a_map_only_by_write: assert property (p_map_only_by_write)
		else $error("input map changed without a write");

	property p_and_gate;
		$rose(stage_on[0]) && $past(cfg_q.bol[0]) |->
			$past(par_on[0]) && $past(cfg_q.ctl[0]);
	endproperty
	a_and_gate: assert property (p_and_gate)
		else $error("and channel turned on without both inputs");

	property p_ovt_reported;
		ovt_evt[0] && !sleep |=> diag_q[osc_pkg::DIAG_OVT_LSB] && !stage_on[0];
	endproperty
	a_ovt_reported: assert property (p_ovt_reported)
		else $error("overtemp not reported or channel left on");

	property p_ovl_limit_stays;
		ovl_evt[1] && !cfg_q.ovl[1] && !sleep && !ovt_s[1] |=>
			stage_on[1] && diag_q[osc_pkg::DIAG_OVL_LSB + 1];
	endproperty
	a_ovl_limit_stays: assert property (p_ovl_limit_stays)
		else $error("limit-only overload turned channel off");

	property p_ovl_shutdown;
		ovl_evt[1] && cfg_q.ovl[1] |=>
			!stage_on[1] && diag_q[osc_pkg::DIAG_OVL_LSB + 1];
	endproperty
	a_ovl_shutdown: assert property (p_ovl_shutdown)
		else $error("shutdown overload left channel on");

	property p_polarity;
		!pol_s && !par_s[0] |-> par_on[0];
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("active low input not seen as on");

	property p_apb_answer;
		access && !pready_q |=> pready_q;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("apb answer not given after one wait state");

	sequence s_diag_write;
		wr_en && paddr == osc_pkg::ADDR_DIAG && !sleep;
	endsequence

	// cleared bits come back only where an event fell in the same cycle
	property p_diag_w1c;
		s_diag_write |=> (diag_q & $past(pwdata[15:0])) ==
			($past({ovl_evt, ovt_evt}) & $past(pwdata[15:0]));
	endproperty
	a_diag_w1c: assert property (p_diag_w1c)
		else $error("diagnosis write one to clear failed");

	property p_diag_sticky;
		!sleep && !(wr_en && paddr == osc_pkg::ADDR_DIAG) |=>
			(diag_q & $past(diag_q)) == $past(diag_q);
	endproperty
	a_diag_sticky: assert property (p_diag_sticky)
		else $error("diagnosis bit lost without a clear");

	property p_or_gate;
		$rose(stage_on[0]) && !$past(cfg_q.bol[0]) |->
			$past(par_on[0]) || $past(cfg_q.ctl[0]);
	endproperty
	a_or_gate: assert property (p_or_gate)
		else $error("or channel turned on with both inputs off");

	property p_polarity_high;
		pol_s && par_s[1] |-> par_on[1];
	endproperty
	a_polarity_high: assert property (p_polarity_high)
		else $error("active high input not seen as on");

	property p_mapped_input;
		par_act[3] && cfg_q.map[5] |-> par_on[5];
	endproperty
	a_mapped_input: assert property (p_mapped_input)
		else $error("mapped input did not reach a mapped channel");

	property p_wake_serial_off;
		$fell(sleep) |-> cfg_q.ctl == 8'h00;
	endproperty
	a_wake_serial_off: assert property (p_wake_serial_off)
		else $error("serial bits not cleared when sleep ends");

	property p_unmapped_err;
		access && !pready_q && !hit |=> pslverr && prdata == 32'h00000000;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("unmapped access without error or with data");
endmodule
`default_nettype wire

// ---- core/osc_pkg.sv ----
// shared constants and types for the octal switch channel control
`default_nettype none
package osc_pkg;
	localparam int NCH      = 8;
	localparam int CLK_NS   = 40;
	// protection and slew times in microseconds
	localparam int FILT_US  = 100;
	localparam int OFF_US   = 10;
	localparam int FAST_US  = 10;
	localparam int SLOW_US  = 50;
	// least times, rounded up to whole cycles
	localparam int FILT_CYC = (FILT_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int OFF_CYC  = (OFF_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int FAST_CYC = (FAST_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int SLOW_CYC = (SLOW_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W    = 12;
	localparam int RAMP_W   = 11;
	// register indices and byte addresses
	localparam int IDX_MAP  = 1;
	localparam int IDX_BOL  = 2;
	localparam int IDX_OVL  = 3;
	localparam int IDX_OVT  = 4;
	localparam int IDX_SLE  = 5;
	localparam int IDX_STA  = 6;
	localparam int IDX_CTL  = 7;
	localparam int IDX_DIAG = 8;
	localparam logic [7:0] ADDR_MAP  = 8'(4 * IDX_MAP);
	localparam logic [7:0] ADDR_BOL  = 8'(4 * IDX_BOL);
	localparam logic [7:0] ADDR_OVL  = 8'(4 * IDX_OVL);
	localparam logic [7:0] ADDR_OVT  = 8'(4 * IDX_OVT);
	localparam logic [7:0] ADDR_SLE  = 8'(4 * IDX_SLE);
	localparam logic [7:0] ADDR_STA  = 8'(4 * IDX_STA);
	localparam logic [7:0] ADDR_CTL  = 8'(4 * IDX_CTL);
	localparam logic [7:0] ADDR_DIAG = 8'(4 * IDX_DIAG);
	// values after reset
	localparam logic [7:0]  MAP_RST  = 8'h08;
	localparam logic [7:0]  ZERO_RST = 8'h00;
	localparam logic [15:0] DIAG_RST = 16'h0000;
	// diagnostic field positions
	localparam int DIAG_OVT_LSB = 0;
	localparam int DIAG_OVL_LSB = 8;

	typedef struct packed {
		logic [7:0] map;
		logic [7:0] bol;
		logic [7:0] ovl;
		logic [7:0] ovt;
		logic [7:0] sle;
		logic [7:0] ctl;
	} osc_cfg_t;
endpackage
`default_nettype wire

// ---- core/osc_sync.sv ----
// three-stage input synchroniser with agreement filter
`default_nettype none
module osc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// asynchronous levels in, filtered levels out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;
	logic [W-1:0] out_d;
	logic [W-1:0] agree;

	// a bit moves only once the second and third stages agree
	always_comb begin
		agree = s2_q ~^ s3_q;
		out_d = (agree & s3_q) | (~agree & out_q);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end else begin
			s1_q  <= async_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign sync_out = out_q;
endmodule
`default_nettype wire

// ---- core/osc_chan.sv ----
// one channel: slew timing, overtemperature and overload protection
`default_nettype none
module osc_chan (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// control
	input  wire logic sleep,
	input  wire logic eff_in,
	input  wire logic ovt_latch,
	input  wire logic ovl_shut,
	input  wire logic slow,
	// sensed conditions, already synchronised
	input  wire logic overtemp,
	input  wire logic limiting,
	// stage state and one-cycle events
	output logic      stage_on,
	output logic      ovt_evt,
	output logic      ovl_evt
);
	logic                     eff_q;
	logic                     on_q;
	logic                     on_d;
	logic                     ovt_lat_q;
	logic                     ovt_lat_d;
	logic                     ovl_lat_q;
	logic                     ovl_lat_d;
	logic [osc_pkg::CNT_W-1:0]  cnt_q;
	logic [osc_pkg::CNT_W-1:0]  cnt_d;
	logic [osc_pkg::CNT_W-1:0]  thresh;
	logic [osc_pkg::RAMP_W-1:0] ramp_q;
	logic [osc_pkg::RAMP_W-1:0] ramp_d;
	logic [osc_pkg::RAMP_W-1:0] ramp_lim;
	logic                     rise;
	logic                     ovt_trip;
	logic                     kill;
	logic                     demand;

	always_comb begin
		rise     = eff_in & ~eff_q;
		ovt_trip = on_q & overtemp & ~sleep;
		ovt_evt  = ovt_trip & ~ovt_lat_q;
		thresh   = ovl_shut ? osc_pkg::CNT_W'(osc_pkg::OFF_CYC)
		                    : osc_pkg::CNT_W'(osc_pkg::FILT_CYC);
		ramp_lim = slow ? osc_pkg::RAMP_W'(osc_pkg::SLOW_CYC)
		                : osc_pkg::RAMP_W'(osc_pkg::FAST_CYC);
		// persistence counter, saturating so one event per episode
		cnt_d   = cnt_q;
		ovl_evt = 1'b0;
		if (!(on_q & limiting) || sleep) begin
			cnt_d = '0;
		end else if (cnt_q == thresh - 1'b1) begin
			ovl_evt = 1'b1;
			cnt_d   = thresh;
		end else if (cnt_q < thresh) begin
			cnt_d = cnt_q + 1'b1;
		end
		// set wins over clear on both latches
		ovt_lat_d = ovt_lat_q;
		if (ovt_trip) begin
			ovt_lat_d = 1'b1;
		end else if (ovt_latch) begin
			if (rise && !overtemp) begin
				ovt_lat_d = 1'b0;
			end
		end else if (!overtemp) begin
			ovt_lat_d = 1'b0;
		end
		ovl_lat_d = ovl_lat_q;
		if (ovl_evt && ovl_shut) begin
			ovl_lat_d = 1'b1;
		end else if (rise) begin
			ovl_lat_d = 1'b0;
		end
		if (sleep) begin
			ovt_lat_d = 1'b0;
			ovl_lat_d = 1'b0;
		end
		// protection switches off at once, normal moves wait out the slew
		kill   = sleep | ovt_trip | (ovl_evt & ovl_shut);
		demand = eff_in & ~ovt_lat_q & ~ovl_lat_q & ~sleep;
		on_d   = on_q;
		ramp_d = '0;
		if (kill) begin
			on_d = 1'b0;
		end else if (demand != on_q) begin
			if (ramp_q == ramp_lim - 1'b1) begin
				on_d = demand;
			end else begin
				ramp_d = ramp_q + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eff_q     <= 1'b0;
			on_q      <= 1'b0;
			ovt_lat_q <= 1'b0;
			ovl_lat_q <= 1'b0;
			cnt_q     <= '0;
			ramp_q    <= '0;
		end else begin
			eff_q     <= eff_in;
			on_q      <= on_d;
			ovt_lat_q <= ovt_lat_d;
			ovl_lat_q <= ovl_lat_d;
			cnt_q     <= cnt_d;
			ramp_q    <= ramp_d;
		end
	end

	assign stage_on = on_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_off_no_ovt;
		!on_q && !ovt_lat_q |=> !ovt_lat_q;
	endproperty
	a_off_no_ovt: assert property (p_off_no_ovt)
		else $error("overtemp latch set on an off channel");

	property p_ovl_latch_off;
		ovl_lat_q |=> !on_q;
	endproperty
	a_ovl_latch_off: assert property (p_ovl_latch_off)
		else $error("channel on while overload latch set");

	property p_ovt_latch_hold;
		ovt_latch && ovt_lat_q && !rise && !sleep |=> ovt_lat_q;
	endproperty
	a_ovt_latch_hold: assert property (p_ovt_latch_hold)
		else $error("overtemp latch cleared without input rise");

	property p_auto_restart;
		!ovt_latch && ovt_lat_q && !overtemp && !on_q |=> !ovt_lat_q;
	endproperty
	a_auto_restart: assert property (p_auto_restart)
		else $error("auto restart latch not released after cooling");

	property p_slew_fast;
		$rose(on_q) && !$past(slow) |-> $past(ramp_q) == ramp_lim - 1'b1;
	endproperty
	a_slew_fast: assert property (p_slew_fast)
		else $error("fast turn-on did not wait the fast slew time");

	property p_ovl_needs_cnt;
		ovl_evt |-> on_q && limiting && cnt_q == thresh - 1'b1;
	endproperty
	a_ovl_needs_cnt: assert property (p_ovl_needs_cnt)
		else $error("overload event without full persistence");
endmodule
`default_nettype wire

// ---- verif/osc_mcu_model.sv ----
// microcontroller side: parallel inputs, polarity pin and reset pin
`default_nettype none
module osc_mcu_model (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// levels the bench asks for
	input  wire logic [3:0] par_req,
	input  wire logic       pol_req,
	input  wire logic       rst_req,
	// pins toward the device
	output logic      [3:0] par_in,
	output logic            input_polarity_select,
	output logic            reset_pin_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// pins move only just after an edge, as a port register would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			par_in <= 4'h0;
			input_polarity_select <= 1'b1;
			reset_pin_n <= 1'b1;
		end else begin
			par_in <= par_req;
			input_polarity_select <= pol_req;
			reset_pin_n <= rst_req;
		end
	end
endmodule
`default_nettype wire

// ---- verif/octal_switch_channel_control_bench.sv ----
// self-checking bench for the octal switch channel control
`default_nettype none
module octal_switch_channel_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  par_req = 4'h0;
	logic [3:0]  par_in;
	logic        pol_req = 1'b1;
	logic        pol;
	logic        rst_req = 1'b1;
	logic        rst_n;
	logic [7:0]  hot = 8'h00;
	logic [7:0]  lim = 8'h00;
	logic [7:0]  stage;
	logic [7:0]  slow;
	logic [31:0] q;
	logic        e;
	int          fail_count = 0;
	int          checks = 0;

	always #20 pclk = ~pclk;

	osc_mcu_model mcu_u (.pclk(pclk), .presetn(presetn), .par_req(par_req),
		.pol_req(pol_req), .rst_req(rst_req), .par_in(par_in),
		.input_polarity_select(pol), .reset_pin_n(rst_n));

	osc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .par_in(par_in),
		.input_polarity_select(pol), .reset_pin_n(rst_n),
		.overtemp_sense(hot), .current_limit_sense(lim),
		.power_output_stage(stage), .slew_slow(slow));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic st(input logic [7:0] exp);
		chk({24'h0, stage}, {24'h0, exp});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			fail_count++;
			give_verdict();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	task automatic done(input string name);
		$display("test %s finished at %0t", name, $time);
	endtask

	// expected stage levels from pins and settings
	function automatic logic [7:0] want(input logic [3:0] p,
		input logic pl, input logic [7:0] m, input logic [7:0] b,
		input logic [7:0] c);
		logic [3:0] a;
		logic [7:0] r;
		a = pl ? p : ~p;
		r = {5'h00, a[2:0]} | (m & {8{a[3]}});
		return (b & r & c) | (~b & (r | c));
	endfunction

	initial begin
		logic [7:0] m;
		logic [7:0] b;
		logic [7:0] c;
		logic [3:0] p;
		logic       pl;
		void'($urandom(62));
		cyc(5);
		presetn <= 1'b1;
		cyc(10);
		rd(osc_pkg::ADDR_MAP, 32'h8);
		for (int k = 2; k <= 8; k++) begin
			rd(8'(4 * k), 32'h0);
		end
		wr(osc_pkg::ADDR_STA, 32'hff);
		rd(osc_pkg::ADDR_STA, 32'h0);
		rd(8'h3c, 32'h0);
		chk({31'h0, e}, 32'h1);
		done("reset values");
		for (int t = 0; t < 11; t++) begin
			{m, b, c, p, pl} = 29'($urandom);
			if (t == 0) {m, b, c, p, pl} = {24'hffffff, 4'h8, 1'b1};
			if (t == 1) {m, b, c, p, pl} = {24'hff0000, 4'h0, 1'b0};
			if (t == 2) {m, b, c, p, pl} = {24'h00ff0f, 4'hf, 1'b1};
			wr(osc_pkg::ADDR_MAP, {24'h0, m});
			wr(osc_pkg::ADDR_BOL, {24'h0, b});
			wr(osc_pkg::ADDR_CTL, {24'h0, c});
			par_req <= p;
			pol_req <= pl;
			cyc(300);
			st(want(p, pl, m, b, c));
			rd(osc_pkg::ADDR_STA, {24'h0, want(p, pl, m, b, c)});
		end
		done("combination");
		wr(osc_pkg::ADDR_MAP, 32'h0);
		wr(osc_pkg::ADDR_BOL, 32'h0);
		wr(osc_pkg::ADDR_CTL, 32'hff);
		par_req <= 4'h0;
		pol_req <= 1'b1;
		wr(osc_pkg::ADDR_SLE, 32'h80);
		cyc(1300);
		chk({24'h0, slow}, 32'h80);
		wr(osc_pkg::ADDR_CTL, 32'h7e);
		cyc(1000);
		st(8'hfe);
		cyc(300);
		st(8'h7e);
		wr(osc_pkg::ADDR_CTL, 32'hff);
		cyc(1300);
		wr(osc_pkg::ADDR_SLE, 32'h0);
		st(8'hff);
		done("slew");
		hot <= 8'h01;
		cyc(8);
		st(8'hfe);
		rd(osc_pkg::ADDR_DIAG, 32'h1);
		hot <= 8'h00;
		cyc(300);
		st(8'hff);
		wr(osc_pkg::ADDR_DIAG, 32'hffff);
		wr(osc_pkg::ADDR_OVT, 32'h01);
		hot <= 8'h01;
		cyc(8);
		hot <= 8'h00;
		cyc(300);
		st(8'hfe);
		wr(osc_pkg::ADDR_DIAG, 32'hffff);
		hot <= 8'h01;
		cyc(20);
		rd(osc_pkg::ADDR_DIAG, 32'h0);
		hot <= 8'h00;
		wr(osc_pkg::ADDR_CTL, 32'hfe);
		cyc(10);
		wr(osc_pkg::ADDR_CTL, 32'hff);
		cyc(300);
		st(8'hff);
		done("overtemperature");
		lim <= 8'h02;
		cyc(2400);
		rd(osc_pkg::ADDR_DIAG, 32'h0);
		cyc(200);
		rd(osc_pkg::ADDR_DIAG, 32'h200);
		st(8'hff);
		lim <= 8'h00;
		wr(osc_pkg::ADDR_DIAG, 32'hffff);
		wr(osc_pkg::ADDR_OVL, 32'h02);
		lim <= 8'h02;
		cyc(200);
		lim <= 8'h00;
		cyc(10);
		lim <= 8'h02;
		cyc(200);
		st(8'hff);
		cyc(100);
		st(8'hfd);
		rd(osc_pkg::ADDR_DIAG, 32'h200);
		lim <= 8'h00;
		cyc(300);
		st(8'hfd);
		wr(osc_pkg::ADDR_CTL, 32'hfd);
		cyc(10);
		wr(osc_pkg::ADDR_CTL, 32'hff);
		cyc(300);
		st(8'hff);
		done("overload");
		wr(osc_pkg::ADDR_MAP, 32'h08);
		par_req <= 4'h8;
		hot <= 8'h01;
		cyc(8);
		hot <= 8'h00;
		rst_req <= 1'b0;
		cyc(10);
		st(8'h00);
		rd(osc_pkg::ADDR_CTL, 32'h0);
		rd(osc_pkg::ADDR_DIAG, 32'h0);
		rst_req <= 1'b1;
		cyc(300);
		st(8'h08);
		done("sleep");
		give_verdict();
	end
endmodule
`default_nettype wire
